// *** hw/lcdd_pin_if.sv ***
/*
 * lcdd_pin_if: host port, strap decoding, display timing pins and lcd drive
 * level selection of a dot-matrix lcd driver, with an apb register window.
 * Assumes all pin inputs are asynchronous to pclk; ram bits and scan bits
 * come from logic on pclk. Tri-state pins are split in/out/oe.
 */
// Function
// [RULE1] host port active only while low-active select low and high-active select high
// [RULE2] data/command flag high marks display data, low marks control data
// [RULE3] serial mode: data on d7, clock on d6, d0-d5 high impedance
// [RULE4] deselected chip keeps all eight data lines high impedance
// [RULE5] interface strap high selects parallel port, low selects serial port
// [RULE6] serial port is write-only, nothing is ever read back
// [RULE7] host holds read and write strobes fixed while serial mode is selected
// [RULE8] clock strap high uses internal oscillator, low takes clock pin
// [RULE9] both chips of a pair share the same clock source strap level
// [RULE10] clock pin is output only for master using internal oscillator
// [RULE11] master generates display timing, slave takes it from master
// [RULE12] alternating pin is output for master, input for slave
// [RULE13] sync pin is output for master, input for slave
// [RULE14] blanking pin is output for master, input for slave
// [RULE15] segment level from ram bit, alternating signal, reversal; power save gives top
// [RULE16] common level from scan bit and alternating signal; power save gives top
// [RULE17] indicator common output uses same waveform on master and slave
// [RULE18] parallel: bus strap high gives 68 style, low gives 80 style
// [RULE19] serial shifts msb first on rising clock, byte formed on eighth edge
// [RULE20] serial shifter and bit counter cleared while chip deselected
`timescale 1ns/1ps
module lcdd_pin_if (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host port pins
	input wire logic chip_select_low_active_n,
	input wire logic chip_select_high_active,
	input wire logic data_command_flag,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic [7:0] data_oe,
	// straps
	input wire logic interface_select_strap,
	input wire logic bus_style_strap,
	input wire logic clock_source_strap,
	input wire logic master_slave_strap,
	// display timing pins
	input wire logic display_clock_pin_in,
	output logic display_clock_pin_out,
	output logic display_clock_pin_oe,
	input wire logic alternating_signal_pin_in,
	output logic alternating_signal_pin_out,
	output logic alternating_signal_pin_oe,
	input wire logic sync_pin_in,
	output logic sync_pin_out,
	output logic sync_pin_oe,
	input wire logic display_blanking_pin_in,
	output logic display_blanking_pin_out,
	output logic display_blanking_pin_oe,
	// internal display side
	input wire logic [lcdd_pkg::LCDD_SEGS-1:0] seg_ram_bits,
	input wire logic [lcdd_pkg::LCDD_INDICATOR_COMMON_OUTPUT-1:0] scan_bits,
	input wire logic indicator_scan,
	output logic [7:0] host_byte,
	output logic host_byte_is_data,
	output logic host_byte_valid,
	output logic display_blank,
	// drive levels
	output logic [2*lcdd_pkg::LCDD_SEGS-1:0] segment_outputs,
	output logic [2*lcdd_pkg::LCDD_INDICATOR_COMMON_OUTPUT-1:0] common_outputs,
	output logic [1:0] indicator_common_output
);
	import lcdd_pkg::*;

	// ==========================================================
	// level functions
	function automatic lcdd_level_t seg_level(input logic bit_v, input logic alt,
		input logic rev, input logic psave);
		logic lit;
		lit = bit_v ^ rev;
		if (psave) begin
			seg_level = LCDD_LVL_TOP;
		end else if (lit) begin
			seg_level = alt ? LCDD_LVL_TOP : LCDD_LVL_BOTTOM;
		end else begin
			seg_level = alt ? LCDD_LVL_HI : LCDD_LVL_LO;
		end
	endfunction

	function automatic lcdd_level_t com_level(input logic sel, input logic alt,
		input logic psave);
		if (psave) begin
			com_level = LCDD_LVL_TOP;
		end else if (sel) begin
			com_level = alt ? LCDD_LVL_BOTTOM : LCDD_LVL_TOP;
		end else begin
			com_level = alt ? LCDD_LVL_HI : LCDD_LVL_LO;
		end
	endfunction

	// ==========================================================
	// pin synchronisers: stage one feeds stage two only
	localparam int NSYNC = 18;
	// reset to idle pin levels: select inactive, write strobe high, so no false edge
	localparam logic [NSYNC-1:0] SYNC_IDLE = 18'h00220;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic [NSYNC-1:0] pin_raw;
	assign pin_raw = {data_in, chip_select_low_active_n, chip_select_high_active,
		data_command_flag, read_strobe, write_strobe, interface_select_strap,
		bus_style_strap, clock_source_strap, master_slave_strap, display_clock_pin_in};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end
	logic [7:0] din_s;
	logic csn_s, csh_s, dc_s, rd_s, wr_s, par_s, bus68_s, cls_s, ms_s, dclk_s;
	assign {din_s, csn_s, csh_s, dc_s, rd_s, wr_s, par_s, bus68_s, cls_s, ms_s, dclk_s} = sync2_q;

	// slave-side timing pins, own synchronisers
	logic [2:0] tsync1_q;
	logic [2:0] tsync2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsync1_q <= '0;
			tsync2_q <= '0;
		end else begin
			tsync1_q <= {alternating_signal_pin_in, sync_pin_in, display_blanking_pin_in};
			tsync2_q <= tsync1_q;
		end
	end

	logic selected;
	assign selected = !csn_s && csh_s; // RULE1

	// previous strobe levels for edge detection
	logic rd_p_q, wr_p_q, dclk_p_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_p_q <= 1'b0;
			wr_p_q <= 1'b1;
			dclk_p_q <= 1'b0;
		end else begin
			rd_p_q <= rd_s;
			wr_p_q <= wr_s;
			dclk_p_q <= dclk_s;
		end
	end

	// ==========================================================
	// parallel write capture
	logic par_wr_ev;
	logic par_rd_act;
	always_comb begin
		if (bus68_s) begin
			par_wr_ev = rd_p_q && !rd_s && !wr_s; // RULE18
			par_rd_act = rd_s && wr_s;
		end else begin
			par_wr_ev = !wr_p_q && wr_s; // RULE18
			par_rd_act = !rd_s;
		end
	end

	// ==========================================================
	// serial shifter
	logic [6:0] shift_q;
	logic [2:0] bit_cnt_q;
	logic sclk_p_q;
	logic sclk_rise;
	assign sclk_rise = !sclk_p_q && din_s[6]; // RULE3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= 7'h00;
			bit_cnt_q <= 3'h0;
			sclk_p_q <= 1'b0;
		end else begin
			sclk_p_q <= din_s[6];
			if (!selected || par_s) begin
				shift_q <= 7'h00; // RULE20
				bit_cnt_q <= 3'h0; // RULE20
			end else if (sclk_rise) begin
				shift_q <= {shift_q[5:0], din_s[7]}; // RULE19
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end
		end
	end

	// ==========================================================
	// received byte
	logic ser_byte_ev;
	assign ser_byte_ev = selected && !par_s && sclk_rise && (bit_cnt_q == 3'h7); // RULE19
	logic [15:0] byte_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_byte <= 8'h00;
			host_byte_is_data <= 1'b0;
			host_byte_valid <= 1'b0;
			byte_cnt_q <= 16'h0000;
		end else begin
			host_byte_valid <= 1'b0;
			if (selected && par_s && par_wr_ev) begin // RULE5
				host_byte <= din_s;
				host_byte_is_data <= dc_s; // RULE2
				host_byte_valid <= 1'b1;
				byte_cnt_q <= byte_cnt_q + 16'h0001;
			end else if (ser_byte_ev) begin
				host_byte <= {shift_q, din_s[7]};
				host_byte_is_data <= dc_s; // RULE2
				host_byte_valid <= 1'b1;
				byte_cnt_q <= byte_cnt_q + 16'h0001;
			end
		end
	end

	// ==========================================================
	// data bus drive
	logic [15:0] rdata_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= 8'h00;
			data_oe <= 8'h00;
		end else begin
			data_out <= dc_s ? rdata_q[7:0] : rdata_q[15:8];
			// serial mode never drives: reads are impossible there
			if (selected && par_s && par_rd_act) begin // RULE6
				data_oe <= 8'hFF;
			end else begin
				data_oe <= 8'h00; // RULE4 RULE3
			end
		end
	end

	// ==========================================================
	// display clock
	logic [7:0] osc_cnt_q;
	logic osc_q;
	logic dclk_tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt_q <= 8'h00;
			osc_q <= 1'b0;
		end else if (osc_cnt_q == 8'(LCDD_DCLK_HALF_CYC - 1)) begin
			osc_cnt_q <= 8'h00;
			osc_q <= !osc_q;
		end else begin
			osc_cnt_q <= osc_cnt_q + 8'h01;
		end
	end
	// the divider reaches a rising edge when it wraps with the output low
	assign dclk_tick = cls_s ? (osc_cnt_q == 8'(LCDD_DCLK_HALF_CYC - 1) && !osc_q)
		: (!dclk_p_q && dclk_s); // RULE8

	// ==========================================================
	// master frame timing
	logic [6:0] line_q;
	logic alt_q, frame_sync_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 7'h00;
			alt_q <= 1'b0;
			frame_sync_q <= 1'b0;
		end else if (ms_s && dclk_tick) begin // RULE11
			if (line_q == 7'(LCDD_LINES - 1)) begin
				line_q <= 7'h00;
				alt_q <= !alt_q;
				frame_sync_q <= 1'b1;
			end else begin
				line_q <= line_q + 7'h01;
				frame_sync_q <= 1'b0;
			end
		end
	end

	logic [2:0] ctrl_q;
	logic alt_eff, blank_eff;
	assign alt_eff = ms_s ? alt_q : tsync2_q[2]; // RULE12
	assign blank_eff = ms_s ? ctrl_q[LCDD_CTRL_BLANK_BIT] : tsync2_q[0]; // RULE14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_clock_pin_out <= 1'b0;
			display_clock_pin_oe <= 1'b0;
			alternating_signal_pin_out <= 1'b0;
			alternating_signal_pin_oe <= 1'b0;
			sync_pin_out <= 1'b0;
			sync_pin_oe <= 1'b0;
			display_blanking_pin_out <= 1'b0;
			display_blanking_pin_oe <= 1'b0;
			display_blank <= 1'b0;
		end else begin
			display_clock_pin_out <= osc_q;
			display_clock_pin_oe <= ms_s && cls_s; // RULE10
			alternating_signal_pin_out <= alt_q;
			alternating_signal_pin_oe <= ms_s; // RULE12
			sync_pin_out <= frame_sync_q;
			sync_pin_oe <= ms_s; // RULE13
			display_blanking_pin_out <= ctrl_q[LCDD_CTRL_BLANK_BIT];
			display_blanking_pin_oe <= ms_s; // RULE14
			display_blank <= blank_eff;
		end
	end

	// ==========================================================
	// drive levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segment_outputs <= '0;
			common_outputs <= '0;
			indicator_common_output <= 2'h0;
		end else begin
			for (int i = 0; i < LCDD_SEGS; i++) begin
				segment_outputs[2*i +: 2] <= seg_level(seg_ram_bits[i], alt_eff,
					ctrl_q[LCDD_CTRL_REVERSE_BIT], ctrl_q[LCDD_CTRL_PSAVE_BIT]); // RULE15
			end
			for (int j = 0; j < LCDD_INDICATOR_COMMON_OUTPUT; j++) begin
				common_outputs[2*j +: 2] <= com_level(scan_bits[j], alt_eff,
					ctrl_q[LCDD_CTRL_PSAVE_BIT]); // RULE16
			end
			// shared alternating signal keeps both chips identical here
			indicator_common_output <= com_level(indicator_scan, alt_eff,
				ctrl_q[LCDD_CTRL_PSAVE_BIT]); // RULE17
		end
	end

	// ==========================================================
	// apb slave, zero wait states
	logic setup, access, mapped;
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign mapped = (paddr == LCDD_CTRL_OFS) || (paddr == LCDD_STAT_OFS) ||
		(paddr == LCDD_CNT_OFS) || (paddr == LCDD_RDATA_OFS);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				case (paddr)
					LCDD_CTRL_OFS: prdata <= {29'h0, ctrl_q};
					LCDD_STAT_OFS: prdata <= {20'h0, alt_eff, ms_s, !par_s,
						host_byte_is_data, host_byte};
					LCDD_CNT_OFS: prdata <= {16'h0, byte_cnt_q};
					LCDD_RDATA_OFS: prdata <= {16'h0, rdata_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= LCDD_CTRL_RESET;
			rdata_q <= LCDD_RDATA_RESET;
		end else if (access && pwrite && paddr == LCDD_CTRL_OFS) begin
			ctrl_q <= pwdata[2:0];
		end else if (access && pwrite && paddr == LCDD_RDATA_OFS) begin
			rdata_q <= pwdata[15:0];
		end
	end

	// ==========================================================
	// assertions
	property p_desel_quiet;
		@(posedge pclk) disable iff (!presetn)
		!selected |=> data_oe == 8'h00;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("bus driven while deselected"); // RULE4

	property p_serial_quiet;
		@(posedge pclk) disable iff (!presetn)
		!par_s |=> data_oe == 8'h00;
	endproperty
	a_serial_quiet: assert property (p_serial_quiet) else $error("serial mode drove bus"); // RULE6

	property p_par_read;
		@(posedge pclk) disable iff (!presetn)
		selected && par_s && par_rd_act |=> data_oe == 8'hFF;
	endproperty
	a_par_read: assert property (p_par_read) else $error("parallel read not driven"); // RULE1

	property p_ser_byte;
		@(posedge pclk) disable iff (!presetn)
		ser_byte_ev |=> host_byte_valid && host_byte == {$past(shift_q), $past(din_s[7])}
			&& host_byte_is_data == $past(dc_s);
	endproperty
	a_ser_byte: assert property (p_ser_byte) else $error("serial byte wrong"); // RULE19

	property p_ser_reset;
		@(posedge pclk) disable iff (!presetn)
		!selected |=> bit_cnt_q == 3'h0 && shift_q == 7'h00;
	endproperty
	a_ser_reset: assert property (p_ser_reset) else $error("shifter not cleared"); // RULE20

	property p_par68_write;
		@(posedge pclk) disable iff (!presetn)
		selected && par_s && bus68_s && rd_p_q && !rd_s && !wr_s |=>
			host_byte_valid && host_byte == $past(din_s);
	endproperty
	a_par68_write: assert property (p_par68_write) else $error("68 write lost"); // RULE18

	property p_dclk_dir;
		@(posedge pclk) disable iff (!presetn)
		##1 display_clock_pin_oe == $past(ms_s && cls_s);
	endproperty
	a_dclk_dir: assert property (p_dclk_dir) else $error("clock pin direction"); // RULE10

	property p_timing_dir;
		@(posedge pclk) disable iff (!presetn)
		$rose(ms_s) |=> alternating_signal_pin_oe && sync_pin_oe && display_blanking_pin_oe;
	endproperty
	a_timing_dir: assert property (p_timing_dir) else $error("timing pins not output"); // RULE13

	property p_psave;
		@(posedge pclk) disable iff (!presetn)
		ctrl_q[LCDD_CTRL_PSAVE_BIT] |=> segment_outputs[1:0] == LCDD_LVL_TOP
			&& common_outputs[1:0] == LCDD_LVL_TOP;
	endproperty
	a_psave: assert property (p_psave) else $error("power save level wrong"); // RULE15

	property p_com_sel;
		@(posedge pclk) disable iff (!presetn)
		!ctrl_q[LCDD_CTRL_PSAVE_BIT] && scan_bits[0] && alt_eff |=>
			common_outputs[1:0] == LCDD_LVL_BOTTOM;
	endproperty
	a_com_sel: assert property (p_com_sel) else $error("selected common level wrong"); // RULE16

	c_ser_byte: cover property (@(posedge pclk) disable iff (!presetn) ser_byte_ev);
	c_par_read: cover property (@(posedge pclk) disable iff (!presetn)
		selected && par_s && par_rd_act);
	c_frame: cover property (@(posedge pclk) disable iff (!presetn) $rose(frame_sync_q));

endmodule

// *** hw/lcdd_pkg.sv ***
/*
 * lcdd_pkg: shared constants for the lcd driver pin interface.
 * Assumes a 10 MHz pclk and an apb master with 32-bit data.
 */
package lcdd_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] LCDD_CTRL_OFS = 8'h00;
	localparam logic [7:0] LCDD_STAT_OFS = 8'h04;
	localparam logic [7:0] LCDD_CNT_OFS = 8'h08;
	localparam logic [7:0] LCDD_RDATA_OFS = 8'h0C;

	// ==========================================================
	// field positions
	localparam int LCDD_CTRL_REVERSE_BIT = 0;
	localparam int LCDD_CTRL_PSAVE_BIT = 1;
	localparam int LCDD_CTRL_BLANK_BIT = 2;
	localparam int LCDD_STAT_DC_BIT = 8;
	localparam int LCDD_STAT_SERIAL_BIT = 9;
	localparam int LCDD_STAT_MASTER_BIT = 10;
	localparam int LCDD_STAT_ALT_BIT = 11;
	localparam logic [2:0] LCDD_CTRL_RESET = 3'h0;
	localparam logic [15:0] LCDD_RDATA_RESET = 16'h0000;

	// ==========================================================
	// drive level codes
	typedef enum logic [1:0] {
		LCDD_LVL_TOP = 2'h0,
		LCDD_LVL_HI = 2'h1,
		LCDD_LVL_LO = 2'h2,
		LCDD_LVL_BOTTOM = 2'h3
	} lcdd_level_t;

	// ==========================================================
	// widths and timing
	localparam int LCDD_SEGS = 224;
	localparam int LCDD_INDICATOR_COMMON_OUTPUT = 64;
	localparam int LCDD_LINES = 65;
	localparam int LCDD_CLK_NS = 100;
	localparam int LCDD_DCLK_PERIOD_NS = 800;
	localparam int LCDD_DCLK_HALF_CYC = LCDD_DCLK_PERIOD_NS / (2 * LCDD_CLK_NS);

endpackage

// *** tb/lcdd_host_model.sv ***
/*
 * lcdd_host_model: behavioural microprocessor on the host port pins.
 * Assumes pclk from the bench; every pin changes just after a pclk rise.
 */
`timescale 1ns/1ps
module lcdd_host_model (
	// mode
	input wire logic pclk,
	input wire logic bus_68,
	input wire logic serial,
	// host pins
	output logic cs_n,
	output logic cs_h,
	output logic dc,
	output logic rd_s,
	output logic wr_s,
	output logic [7:0] d_drv
);
	// ==========
	// levels
	initial begin
		{cs_n, cs_h, dc, rd_s, wr_s} = 5'h13;
		d_drv = 8'h00;
	end
	// open lines in serial mode toggle, so a stale value never passes
	always @(posedge pclk) begin
		if (serial) begin
			d_drv[5:0] <= ~d_drv[5:0];
		end
	end
	// ==========
	// transfers
	task automatic select(input bit n, input bit h);
		@(posedge pclk);
		cs_n <= n;
		cs_h <= h;
	endtask
	// 68 style keeps its direction while e falls, so the write edge still sees it
	task automatic idle();
		@(posedge pclk);
		rd_s <= ~bus_68;
		wr_s <= bus_68 ? wr_s : 1'b1;
	endtask
	task automatic strobe(input bit rd, input bit dcv, input logic [7:0] b);
		@(posedge pclk);
		dc <= dcv;
		d_drv <= b;
		rd_s <= bus_68 | ~rd;
		wr_s <= rd;
	endtask
	// both strobes stay at their fixed levels here
	task automatic ser_bits(input bit dcv, input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge pclk);
			dc <= dcv;
			d_drv[7:6] <= {b[i], 1'b0};
			repeat (4) @(posedge pclk);
			d_drv[6] <= 1'b1;
			if (i > 8 - n) begin
				repeat (3) @(posedge pclk);
			end
		end
	endtask
endmodule

// *** tb/lcdd_pin_if_tb.sv ***
/*
 * lcdd_pin_if_tb: self-checking bench for the lcd driver pin interface.
 * Assumes lcdd_pkg, lcdd_pin_if and lcdd_host_model are compiled first.
 */
`timescale 1ns/1ps
module lcdd_pin_if_tb;
	import lcdd_pkg::*;
	// ==========
	// signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, got, last_dc;
	logic iface, bus68, clks, ms, ext_clk, ext_run, alt_in, blank_in, ind_scan;
	logic cs_n, cs_h, dc, rd_s, wr_s, hb_dc, hb_v, dblank;
	logic clk_o, clk_oe, alt_o, alt_oe, sync_o, sync_oe, blk_o, blk_oe;
	logic [7:0] paddr, data_in, data_out, data_oe, host_byte, d_drv, disp_b, stat_b, last_b;
	logic [31:0] pwdata, prdata, rd;
	logic [LCDD_SEGS-1:0] ram;
	logic [LCDD_INDICATOR_COMMON_OUTPUT-1:0] scan;
	logic [2*LCDD_SEGS-1:0] seg_o;
	logic [2*LCDD_INDICATOR_COMMON_OUTPUT-1:0] com_o;
	logic [1:0] ind_o;
	int failures, n_checks;

	assign data_in = (data_oe & data_out) | (~data_oe & d_drv);
	always #50 pclk = ~pclk;
	// display clock pin: 800 ns, phase unrelated to pclk, low while stopped
	initial begin
		ext_clk = 1'b0;
		#37;
		forever #400 ext_clk = ext_run ? ~ext_clk : 1'b0;
	end

	lcdd_pin_if u_lcdd_pin_if (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.chip_select_low_active_n(cs_n), .chip_select_high_active(cs_h),
		.data_command_flag(dc), .read_strobe(rd_s), .write_strobe(wr_s),
		.data_in, .data_out, .data_oe, .interface_select_strap(iface),
		.bus_style_strap(bus68), .clock_source_strap(clks), .master_slave_strap(ms),
		.display_clock_pin_in(ext_clk), .display_clock_pin_out(clk_o),
		.display_clock_pin_oe(clk_oe), .alternating_signal_pin_in(alt_in),
		.alternating_signal_pin_out(alt_o), .alternating_signal_pin_oe(alt_oe),
		.sync_pin_in(1'b0), .sync_pin_out(sync_o), .sync_pin_oe(sync_oe),
		.display_blanking_pin_in(blank_in), .display_blanking_pin_out(blk_o),
		.display_blanking_pin_oe(blk_oe), .seg_ram_bits(ram), .scan_bits(scan),
		.indicator_scan(ind_scan), .host_byte, .host_byte_is_data(hb_dc),
		.host_byte_valid(hb_v), .display_blank(dblank), .segment_outputs(seg_o),
		.common_outputs(com_o), .indicator_common_output(ind_o)
	);
	lcdd_host_model u_lcdd_host_model (
		.pclk, .bus_68(bus68), .serial(~iface), .cs_n, .cs_h, .dc, .rd_s, .wr_s, .d_drv
	);

	// ==========
	// tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (failures == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		got = 1'b0;
		for (int k = 0; k < 20 && !got; k++) begin
			@(posedge pclk);
			got = (pready === 1'b1);
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (!got) begin
			failures++;
			end_sim();
		end
	endtask
	task automatic wait_byte(input bit want, input logic [7:0] b, input bit dcv);
		got = 1'b0;
		for (int k = 0; k < 12 && !got; k++) begin
			@(negedge pclk);
			got = (hb_v === 1'b1);
		end
		chk("byte taken", got, want);
		if (want) begin
			chk("host byte", host_byte, b);
			chk("data flag", hb_dc, dcv);
			{last_b, last_dc} = {b, dcv};
			if (!got) end_sim();
		end
	endtask
	task automatic moves(ref logic s, input bit want, input string what);
		logic s0;
		s0 = s;
		got = 1'b0;
		for (int k = 0; k < 1300 && !got; k++) begin
			@(negedge pclk);
			got = (s !== s0);
		end
		chk(what, got, want);
		if (want && !got) end_sim();
	endtask
	task automatic par_wr(input bit n, input bit h, input bit dcv, input logic [7:0] b);
		u_lcdd_host_model.select(n, h);
		u_lcdd_host_model.strobe(1'b0, dcv, b);
		repeat (4) @(posedge pclk);
		u_lcdd_host_model.idle();
		wait_byte(!n && h, b, dcv);
		u_lcdd_host_model.select(1'b1, 1'b0);
	endtask
	task automatic par_rd(input bit n, input bit h, input bit dcv);
		u_lcdd_host_model.select(n, h);
		u_lcdd_host_model.strobe(1'b1, dcv, 8'h00);
		repeat (5) @(negedge pclk);
		chk("read oe", data_oe, (!n && h) ? 8'hFF : 8'h00);
		if (!n && h) chk("read data", data_out, dcv ? disp_b : stat_b);
		u_lcdd_host_model.idle();
		repeat (5) @(negedge pclk);
		chk("oe released", data_oe, 8'h00);
		u_lcdd_host_model.select(1'b1, 1'b0);
	endtask
	task automatic ser_wr(input bit n, input bit h, input bit dcv, input logic [7:0] b);
		u_lcdd_host_model.select(n, h);
		repeat (3) @(posedge pclk);
		u_lcdd_host_model.ser_bits(dcv, b, 8);
		wait_byte(!n && h, b, dcv);
		chk("serial oe", data_oe, 8'h00);
		u_lcdd_host_model.select(1'b1, 1'b0);
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic [1:0] seg_lvl(input logic b, a, r, p);
		if (p) return LCDD_LVL_TOP;
		if (b ^ r) return a ? LCDD_LVL_TOP : LCDD_LVL_BOTTOM;
		return a ? LCDD_LVL_HI : LCDD_LVL_LO;
	endfunction
	function automatic logic [1:0] com_lvl(input logic s, a, p);
		if (p) return LCDD_LVL_TOP;
		if (s) return a ? LCDD_LVL_BOTTOM : LCDD_LVL_TOP;
		return a ? LCDD_LVL_HI : LCDD_LVL_LO;
	endfunction

	// ==========
	// stimulus
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{iface, bus68, clks, ms} = 4'hB;
		{ext_run, alt_in, blank_in, ind_scan} = 4'h0;
		{ram, scan} = '0;
		failures = 0;
		n_checks = 0;
		void'($urandom(90400));
		disp_b = 8'($urandom);
		stat_b = 8'($urandom);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, LCDD_CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, {29'h0, LCDD_CTRL_RESET});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		apb(1'b1, LCDD_RDATA_OFS, {16'h0, stat_b, disp_b});
		for (int s = 0; s < 2; s++) begin
			@(posedge pclk);
			bus68 <= s[0];
			repeat (4) @(posedge pclk);
			u_lcdd_host_model.idle();
			for (int i = 0; i < 4; i++) begin
				par_wr(1'b0, 1'b1, i[0], 8'($urandom));
			end
			par_wr(1'b0, 1'b1, 1'b1, 8'hFF);
			par_wr(1'b1, 1'b1, 1'b1, 8'h5A);
			par_wr(1'b0, 1'b0, 1'b0, 8'hA5);
			par_rd(1'b0, 1'b1, 1'b1);
			par_rd(1'b0, 1'b1, 1'b0);
			par_rd(1'b1, 1'b1, 1'b1);
		end
		@(posedge pclk);
		iface <= 1'b0;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			if (i == 2) begin
				u_lcdd_host_model.select(1'b0, 1'b1);
				u_lcdd_host_model.ser_bits(1'b1, 8'hFF, 3);
				u_lcdd_host_model.select(1'b1, 1'b0);
			end
			ser_wr(i == 5, 1'b1, 1'($urandom), i == 3 ? 8'h01 : 8'($urandom));
		end
		apb(1'b0, LCDD_STAT_OFS, 32'h0);
		chk("stat", rd[10:0], {2'b11, last_dc, last_b});
		apb(1'b0, LCDD_CNT_OFS, 32'h0);
		chk("byte count", rd, 32'h0000_000F);
		for (int m = 0; m < 4; m++) begin
			@(posedge pclk);
			{ms, clks} <= m[1:0];
			repeat (6) @(negedge pclk);
			chk("clock oe", clk_oe, m[1] & m[0]);
			chk("alt oe", alt_oe, m[1]);
			chk("sync oe", sync_oe, m[1]);
			chk("blank oe", blk_oe, m[1]);
		end
		moves(clk_o, 1'b1, "clock out");
		moves(alt_o, 1'b1, "alt oscillator");
		moves(sync_o, 1'b1, "sync out");
		@(posedge pclk);
		clks <= 1'b0;
		repeat (4) @(posedge pclk);
		moves(alt_o, 1'b0, "alt stopped");
		ext_run = 1'b1;
		moves(alt_o, 1'b1, "alt clock pin");
		apb(1'b1, LCDD_CTRL_OFS, 32'h4);
		repeat (4) @(negedge pclk);
		chk("blank out", {blk_o, dblank}, 2'b11);
		@(posedge pclk);
		{ms, blank_in} <= 2'b01;
		apb(1'b1, LCDD_CTRL_OFS, 32'h0);
		repeat (4) @(negedge pclk);
		chk("blank slave", dblank, 1'b1);
		@(posedge pclk);
		blank_in <= 1'b0;
		// slave mode, so the alternating level comes straight from the pin
		for (int c = 0; c < 8; c++) begin
			@(posedge pclk);
			alt_in <= c[2];
			ind_scan <= 1'($urandom);
			for (int k = 0; k < LCDD_SEGS; k++) ram[k] <= 1'($urandom);
			for (int k = 0; k < LCDD_INDICATOR_COMMON_OUTPUT; k++) scan[k] <= 1'($urandom);
			apb(1'b1, LCDD_CTRL_OFS, {30'h0, c[1], c[0]});
			repeat (5) @(negedge pclk);
			for (int k = 0; k < LCDD_SEGS; k++) begin
				chk("segment", seg_o[2*k+:2], seg_lvl(ram[k], c[2], c[0], c[1]));
			end
			for (int k = 0; k < LCDD_INDICATOR_COMMON_OUTPUT; k++) begin
				chk("common", com_o[2*k+:2], com_lvl(scan[k], c[2], c[1]));
			end
			chk("indicator", ind_o, com_lvl(ind_scan, c[2], c[1]));
		end
		end_sim();
	end
endmodule
